// >>> dv/urcl_checker.sv
// assertion checker for the rom configuration loader
`timescale 1ns/100ps
`default_nettype none
module urcl_checker (
  input wire logic        i_mclk, i_reset_n, i_bus_request, i_arb_peer_in, i_target_is_atapi,
  input wire logic        o_load_done, o_image_valid, o_power_source_sel, o_clock_speed_sel,
  input wire logic        o_clk_is_7m5, o_combo_mode, o_dma_capability_enable, o_udma_enable,
  input wire logic        o_mdma_enable, o_pio_enable, o_arb_request_out,
  input wire logic [1:0]  o_device_type,
  input wire logic [15:0] o_tx_types,
  input wire logic [15:0] o_id_vendor
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  property p_pio; o_pio_enable && o_tx_types[0]; endproperty
  a_pio: assert property (p_pio) else $error("pio modes dropped");
  property p_arb; o_load_done && i_bus_request && !i_arb_peer_in |=> o_arb_request_out; endproperty
  a_arb: assert property (p_arb) else $error("bus request not raised");
  property p_peer; i_arb_peer_in |=> !o_arb_request_out; endproperty
  a_peer: assert property (p_peer) else $error("request while peer busy");
  property p_clk; o_load_done |-> o_clk_is_7m5 == (o_power_source_sel && o_clock_speed_sel); endproperty
  a_clk: assert property (p_clk) else $error("clock rate decode wrong");
  property p_combo; o_load_done |-> o_combo_mode == (!o_power_source_sel && o_clock_speed_sel); endproperty
  a_combo: assert property (p_combo) else $error("combo decode wrong");
  property p_ata; o_load_done && (o_device_type == urcl_pkg::DEV_ATA || o_device_type == urcl_pkg::DEV_AUTO
    && !i_target_is_atapi) |-> o_udma_enable == o_dma_capability_enable && o_mdma_enable == o_dma_capability_enable;
  endproperty
  a_ata: assert property (p_ata) else $error("ata dma decode wrong");
  property p_atapi; o_load_done && (o_device_type == urcl_pkg::DEV_ATAPI || o_device_type == urcl_pkg::DEV_AUTO
    && i_target_is_atapi) |-> o_mdma_enable && o_udma_enable == o_dma_capability_enable; endproperty
  a_atapi: assert property (p_atapi) else $error("atapi dma decode wrong");
  property p_bad; $rose(o_load_done) && !o_image_valid |-> o_id_vendor == 16'h0000 && o_tx_types == 16'h000f;
  endproperty
  a_bad: assert property (p_bad) else $error("bad image not ignored");
  property p_done; o_load_done |=> o_load_done [*4]; endproperty
  a_done: assert property (p_done) else $error("load done dropped");
  c_valid: cover property (o_load_done && o_image_valid);
  c_bad: cover property ($rose(o_load_done) && !o_image_valid);
  c_arb: cover property (o_arb_request_out);
endmodule // urcl_checker
bind urcl_loader urcl_checker u_chk (.i_mclk, .i_reset_n, .i_bus_request, .i_arb_peer_in, .i_target_is_atapi,
  .o_load_done, .o_image_valid, .o_power_source_sel, .o_clock_speed_sel, .o_clk_is_7m5, .o_combo_mode,
  .o_dma_capability_enable, .o_udma_enable, .o_mdma_enable, .o_pio_enable, .o_arb_request_out,
  .o_device_type, .o_tx_types, .o_id_vendor);
`default_nettype wire

// >>> dv/urcl_loader_tb.sv
// self-checking bench for the serial rom configuration loader
`timescale 1ns/100ps
`default_nettype none
module urcl_loader_tb;
  logic        i_mclk, i_reset_n, i_target_is_atapi, i_bus_request, i_arb_peer_in, mute, rom_oe;
  logic        o_sda_oe, o_scl_oe, o_load_done, o_image_valid, o_patch_enable, o_power_source_sel;
  logic        o_target_power_ctrl, o_udma_enable, o_mdma_enable, o_pio_enable, o_arb_request_out;
  logic        o_str_wr, o_patch_wr, o_large_rom;
  logic [1:0]  o_device_type, o_str_sel;
  logic [4:0]  o_str_idx;
  logic [7:0]  o_max_power, o_if_class, o_str_data, o_patch_data;
  logic [15:0] o_desc_flags, o_id_vendor, o_id_product, o_bcd_device, o_tx_types, o_patch_addr;
  wire logic   sda = !(o_sda_oe || rom_oe);
  wire logic   scl = !o_scl_oe;
  int          err_total = 0, check_count = 0, n_str = 0, n_patch = 0;
  urcl_loader #(.PATCH_BLOCKS(1), .HALF_CYC(2)) u_dut (.i_mclk, .i_reset_n, .i_sda(sda), .i_scl(scl),
    .i_target_is_atapi,
    .i_bus_request, .i_arb_peer_in, .o_sda_oe, .o_scl_oe, .o_load_done, .o_image_valid, .o_desc_flags,
    .o_id_vendor, .o_id_product, .o_bcd_device, .o_max_power, .o_if_class, .o_if_subclass(), .o_if_protocol(),
    .o_patch_enable, .o_power_source_sel, .o_clock_speed_sel(), .o_clk_is_7m5(), .o_device_type,
    .o_combo_mode(), .o_dma_capability_enable(), .o_target_power_ctrl, .o_tx_types, .o_udma_enable,
    .o_mdma_enable, .o_pio_enable, .o_large_rom, .o_arb_request_out, .o_str_wr, .o_str_sel, .o_str_idx,
    .o_str_data, .o_patch_wr, .o_patch_addr, .o_patch_data);
  urcl_rom_model u_rom (.i_scl(scl), .i_sda(sda), .i_mute(mute), .o_sda_oe(rom_oe));
  initial
  begin
    i_mclk = 0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    check_count++;
    if (got !== exp) begin err_total++; $display("unexpected at %0t: %s", $time, what); end
  endtask
  task automatic final_report;
    $display("mismatches %0d, checks %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_mclk)
  begin
    if (o_str_wr) begin n_str++; chk(o_str_data, u_rom.mem[32 + 32 * o_str_sel + o_str_idx], "string"); end
    if (o_patch_wr) begin n_patch++; chk(o_patch_data, u_rom.mem[128 + o_patch_addr], "patch"); end
  end
  task automatic load(input logic atapi, input logic m);
    @(negedge i_mclk);
    {i_reset_n, i_target_is_atapi, mute, n_str, n_patch} = {1'b0, atapi, m, 64'd0};
    repeat (5) @(negedge i_mclk);
    chk(o_tx_types, 16'h0001, "reset tx types");
    i_reset_n = 1;
    for (int i = 0; i < 30000 && o_load_done !== 1'b1; i++) @(negedge i_mclk);
    if (o_load_done !== 1'b1) begin err_total++; $display("unexpected at %0t: load hang", $time); final_report; end
  endtask
  task automatic t_valid;
    logic [15:0] sum;
    sum = 16'h00ff;
    for (int i = 0; i < 256; i++) u_rom.mem[i] = 8'(i) ^ 8'h5a;
    {u_rom.mem[1], u_rom.mem[0]} = urcl_pkg::VALID_MARK;
    {u_rom.mem[7], u_rom.mem[6]} = 16'h3104; // bus power, 60 mhz, ata, no dma
    {u_rom.mem[25], u_rom.mem[24], u_rom.mem[23], u_rom.mem[22]} = 32'h0010_0008;
    for (int i = 4; i < 256; i++) sum += u_rom.mem[i];
    {u_rom.mem[3], u_rom.mem[2]} = sum;
    load(0, 0);
    chk(o_image_valid, 1, "valid");
    chk(o_desc_flags, {u_rom.mem[5], u_rom.mem[4]}, "flags");
    chk(o_id_vendor, {u_rom.mem[9], u_rom.mem[8]}, "vendor");
    chk(o_id_product, {u_rom.mem[11], u_rom.mem[10]}, "product");
    chk(o_bcd_device, {u_rom.mem[13], u_rom.mem[12]}, "release");
    chk(o_max_power, u_rom.mem[16], "bus max power");
    chk(o_if_class, u_rom.mem[18], "class");
    chk({o_power_source_sel, o_target_power_ctrl, o_device_type}, 4'hf - 4'h1, "mode bits");
    chk(o_tx_types, 16'h0017, "tx types");
    chk({o_udma_enable, o_mdma_enable, o_pio_enable, o_patch_enable}, 4'h3, "dma and patch");
    chk(o_large_rom, 0, "small rom strap");
    chk(16'(n_str), 16'd96, "string count");
    chk(16'(n_patch), 16'd128, "patch count");
  endtask
  task automatic t_arb;
    {i_bus_request, i_arb_peer_in} = 2'b10;
    @(negedge i_mclk);
    chk(o_arb_request_out, 1, "arb raise");
    i_arb_peer_in = 1;
    @(negedge i_mclk);
    chk(o_arb_request_out, 0, "arb peer busy");
    {i_bus_request, i_arb_peer_in} = 2'b00;
  endtask
  task automatic t_bad_sum;
    u_rom.mem[2] ^= 8'h01;
    load(1, 0);
    chk({o_image_valid, o_power_source_sel, o_device_type}, 4'h0, "defaults");
    chk(o_id_vendor, 16'h0000, "default ids");
    chk(o_tx_types, 16'h000f, "default tx types");
    chk({o_udma_enable, o_mdma_enable, o_patch_enable}, 3'b010, "auto atapi dma");
  endtask
  task automatic t_nack;
    load(0, 1);
    chk(o_image_valid, 0, "absent rom");
    chk(o_id_vendor, 16'h0000, "absent rom ids");
  endtask
  initial
  begin
    {i_reset_n, i_target_is_atapi, i_bus_request, i_arb_peer_in, mute} = '0;
    t_valid;
    t_arb;
    t_bad_sum;
    t_nack;
    final_report;
  end
endmodule // urcl_loader_tb
`default_nettype wire

// >>> dv/urcl_rom_model.sv
// behavioural two-wire serial rom holding the image
`timescale 1ns/100ps
`default_nettype none
module urcl_rom_model (
  input  wire logic i_scl,
  input  wire logic i_sda,
  input  wire logic i_mute,
  output logic      o_sda_oe
);
  logic [7:0] mem [0:255];
  logic [7:0] sh;
  logic       rd, first, ack_ok;
  int         bitc, ptr;
  initial {o_sda_oe, rd, first, ack_ok, bitc} = '0;
  // start and stop conditions
  always @(i_sda) if (i_scl === 1'b1)
  begin
    o_sda_oe = 0;
    rd = 0;
    bitc = -1;
    first = !i_sda;
  end
  always @(posedge i_scl)
  begin
    if (!rd && bitc >= 0 && bitc < 8) sh = {sh[6:0], i_sda};
    if (rd && bitc == 8) ack_ok = !i_sda;
  end
  always @(negedge i_scl)
  begin
    bitc = bitc + 1;
    if (bitc == 8 && !rd && first)
    begin
      o_sda_oe = !i_mute && sh[7:1] == urcl_pkg::DEV_ADDR;
      rd = sh[0] && o_sda_oe;
      ack_ok = 1;
      first = 0;
    end
    else if (bitc == 8 && !rd)
    begin
      o_sda_oe = 1;
      ptr = sh;
    end
    else if (bitc == 8)
    begin
      o_sda_oe = 0;
      ptr = ptr + 1;
    end
    else if (bitc == 9)
    begin
      bitc = 0;
      o_sda_oe = 0;
      if (!ack_ok) rd = 0;
    end
    if (rd && bitc < 8) o_sda_oe = !mem[ptr][7 - bitc];
  end
endmodule // urcl_rom_model
`default_nettype wire

// >>> inc/urcl_pkg.sv
// package of constants for the serial rom configuration loader
package urcl_pkg;

  // image byte offsets
  localparam logic [7:0] OFS_MARK       = 8'h00;
  localparam logic [7:0] OFS_SUM        = 8'h02;
  localparam logic [7:0] OFS_FLAGS      = 8'h04;
  localparam logic [7:0] OFS_MODE_CLR   = 8'h06;
  localparam logic [7:0] OFS_MODE_SET   = 8'h07;
  localparam logic [7:0] OFS_VID        = 8'h08;
  localparam logic [7:0] OFS_PID        = 8'h0a;
  localparam logic [7:0] OFS_BCD        = 8'h0c;
  localparam logic [7:0] OFS_PWR_BUS    = 8'h10;
  localparam logic [7:0] OFS_PWR_SELF   = 8'h11;
  localparam logic [7:0] OFS_IF_CLASS   = 8'h12;
  localparam logic [7:0] OFS_IF_SUB     = 8'h13;
  localparam logic [7:0] OFS_IF_PROTO   = 8'h14;
  localparam logic [7:0] OFS_TX_CLR     = 8'h16;
  localparam logic [7:0] OFS_TX_SET     = 8'h18;
  localparam logic [7:0] OFS_PATCH_SW   = 8'h1a;
  localparam logic [7:0] OFS_STR_MAKER  = 8'h20;
  localparam logic [7:0] OFS_STR_PROD   = 8'h40;
  localparam logic [7:0] OFS_STR_SERIAL = 8'h60;
  localparam logic [7:0] OFS_PATCH      = 8'h80;
  localparam int         STR_BYTES      = 32;
  localparam int         PATCH_BLOCK    = 128;
  localparam int         HDR_BYTES      = 128;

  localparam logic [15:0] VALID_MARK    = 16'h55aa;

  // mode byte fields
  localparam int MB_PWR = 0;
  localparam int MB_CLC = 1;
  localparam int MB_DCC = 2;
  localparam int MB_DV0 = 3;
  localparam int MB_DV1 = 4;
  localparam int MB_DPC = 5;
  localparam logic [7:0] MODE_DEFAULT = 8'h00;

  // transfer type bits
  localparam int TX_PIO  = 0;
  localparam int TX_MDMA = 1;
  localparam int TX_UDMA = 2;
  localparam int TX_U66  = 3;
  localparam logic [15:0] TX_DEFAULT = 16'h000f;

  // device type codes
  localparam logic [1:0] DEV_NONE  = 2'h3;
  localparam logic [1:0] DEV_ATA   = 2'h2;
  localparam logic [1:0] DEV_ATAPI = 2'h1;
  localparam logic [1:0] DEV_AUTO  = 2'h0;

  // serial rom timing
  localparam int SCL_NS         = 10000;
  localparam int CLK_NS         = 25;
  localparam int SCL_HALF_CYC   = SCL_NS / (2 * CLK_NS);
  localparam logic [6:0] DEV_ADDR = 7'h50;

  // rom reader commands
  typedef enum logic [1:0] {URCL_OP_START, URCL_OP_WRITE, URCL_OP_READ, URCL_OP_STOP} urcl_op_e;

endpackage

// >>> logic/urcl_loader.sv
// serial rom configuration loader top
// Behaviour
// - at start-up read vendor, product and usb settings from the serial rom
// - word at +00 must equal 55aa to mark the image valid
// - word at +02 is the image_sum_word over the image, read and checked
// - word at +04 gives descriptor override flags
// - byte at +06 clears mode bits
// - byte at +07 sets mode bits
// - words +08, +0a, +0c give vendor, product, device release
// - byte +10 gives max power for bus-powered mode
// - byte +11 gives self-powered max power; +12..+14 interface class fields
// - words +16 and +18 clear and set transfer type bits
// - word +1a switches firmware patching on or off
// - three 32-byte string areas at +20, +40, +60
// - patch modules from +80 in whole 128-byte blocks
// - power bit 1 bus-powered; when bus-powered, clock bit picks 7.5 or 60 mhz, otherwise clock bit 1 selects combo mode
// - device type 11 none, 10 ata, 01 atapi, 00 auto
// - ata target: dma bit clear disables ultra and multiword, set enables both
// - atapi target: dma bit clear disables ultra only
// - pio modes 0 to 4 stay enabled always
// - arbitration out high while requesting bus; peer in high means peer busy
`timescale 1ns/100ps
`default_nettype none
module urcl_loader #(
  parameter int STR_AREA_BYTES = urcl_pkg::STR_BYTES,
  parameter int PATCH_BLOCKS   = 1,
  parameter int HALF_CYC       = urcl_pkg::SCL_HALF_CYC
) (
  input  wire logic       i_mclk,
  input  wire logic       i_reset_n,
  input  wire logic       i_sda,
  input  wire logic       i_scl,
  input  wire logic       i_target_is_atapi,
  input  wire logic       i_bus_request,
  input  wire logic       i_arb_peer_in,
  output logic            o_sda_oe,
  output logic            o_scl_oe,
  output logic            o_load_done,
  output logic            o_image_valid,
  output logic [15:0]     o_desc_flags,
  output logic [15:0]     o_id_vendor,
  output logic [15:0]     o_id_product,
  output logic [15:0]     o_bcd_device,
  output logic [7:0]      o_max_power,
  output logic [7:0]      o_if_class,
  output logic [7:0]      o_if_subclass,
  output logic [7:0]      o_if_protocol,
  output logic            o_patch_enable,
  output logic            o_power_source_sel,
  output logic            o_clock_speed_sel,
  output logic            o_clk_is_7m5,
  output logic [1:0]      o_device_type,
  output logic            o_combo_mode,
  output logic            o_dma_capability_enable,
  output logic            o_target_power_ctrl,
  output logic [15:0]     o_tx_types,
  output logic            o_udma_enable,
  output logic            o_mdma_enable,
  output logic            o_pio_enable,
  output logic            o_large_rom,
  output logic            o_arb_request_out,
  output logic            o_str_wr,
  output logic [1:0]      o_str_sel,
  output logic [4:0]      o_str_idx,
  output logic [7:0]      o_str_data,
  output logic            o_patch_wr,
  output logic [15:0]     o_patch_addr,
  output logic [7:0]      o_patch_data
);

  typedef enum logic [3:0] {
    S_STRAP, S_START, S_DEVW, S_AH, S_AL, S_RSTART, S_DEVR, S_READ, S_STOP, S_DONE
  } urcl_st_e;

  localparam int IMG_BYTES = urcl_pkg::HDR_BYTES + PATCH_BLOCKS * urcl_pkg::PATCH_BLOCK;

  urcl_st_e     st_ff;
  logic         go_ff;
  urcl_pkg::urcl_op_e op_ff;
  logic [7:0]   wd_ff;
  logic         last_ff;
  logic         large_ff;
  logic [15:0]  addr_ff;
  logic [7:0]   hdr_ff [0:31];
  logic [15:0]  sum_ff;
  logic         tw_done;
  logic [7:0]   tw_rdata;
  logic         tw_nack;

  //////////////////////////////////////////////////////////////////////////////
  // rom reader engine
  urcl_twowire #(
    .HALF_CYC (HALF_CYC)
  ) u_tw (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_go      (go_ff),
    .i_op      (op_ff),
    .i_wdata   (wd_ff),
    .i_last    (last_ff),
    .i_sda     (i_sda),
    .o_done    (tw_done),
    .o_rdata   (tw_rdata),
    .o_nack    (tw_nack),
    .o_scl_oe  (o_scl_oe),
    .o_sda_oe  (o_sda_oe)
  );

  //////////////////////////////////////////////////////////////////////////////
  // decode of the loaded header
  wire [15:0] w_mark   = {hdr_ff[1], hdr_ff[0]};
  wire [15:0] w_sum    = {hdr_ff[3], hdr_ff[2]};
  // image_sum_word is the 16-bit sum of all image bytes except the sum word itself
  wire        sum_ok   = (sum_ff - 16'(hdr_ff[2]) - 16'(hdr_ff[3])) == w_sum;
  wire        mark_ok  = (w_mark == urcl_pkg::VALID_MARK);
  wire        valid    = mark_ok && sum_ok;
  wire [7:0]  mode_clr = valid ? hdr_ff[urcl_pkg::OFS_MODE_CLR[4:0]] : 8'h00;
  wire [7:0]  mode_set = valid ? hdr_ff[urcl_pkg::OFS_MODE_SET[4:0]] : 8'h00;
  wire [7:0]  mode     = (urcl_pkg::MODE_DEFAULT & ~mode_clr) | mode_set;
  wire [15:0] tx_clr   = valid ? {hdr_ff[urcl_pkg::OFS_TX_CLR[4:0] + 5'd1],
                                  hdr_ff[urcl_pkg::OFS_TX_CLR[4:0]]} : 16'h0000;
  wire [15:0] tx_set   = valid ? {hdr_ff[urcl_pkg::OFS_TX_SET[4:0] + 5'd1],
                                  hdr_ff[urcl_pkg::OFS_TX_SET[4:0]]} : 16'h0000;
  wire [15:0] tx_raw   = (urcl_pkg::TX_DEFAULT & ~tx_clr) | tx_set;
  wire        power_source_sel      = mode[urcl_pkg::MB_PWR];
  wire        clock_speed_sel      = mode[urcl_pkg::MB_CLC];
  wire        dcc      = mode[urcl_pkg::MB_DCC];
  wire [1:0]  dev      = {mode[urcl_pkg::MB_DV1], mode[urcl_pkg::MB_DV0]};
  wire        slow     = power_source_sel && clock_speed_sel;
  // auto detect resolves to the attached target class
  wire        atapi    = (dev == urcl_pkg::DEV_ATAPI) ||
                         (dev == urcl_pkg::DEV_AUTO && i_target_is_atapi);
  wire        has_dev  = (dev != urcl_pkg::DEV_NONE);
  wire        udma_ok  = has_dev && dcc && tx_raw[urcl_pkg::TX_UDMA];
  wire        mdma_ok  = has_dev && (dcc || atapi) && tx_raw[urcl_pkg::TX_MDMA];
  wire [15:0] tx_types = tx_raw | (16'h0001 << urcl_pkg::TX_PIO);
  wire [15:0] w_patch  = {hdr_ff[urcl_pkg::OFS_PATCH_SW[4:0] + 5'd1], hdr_ff[urcl_pkg::OFS_PATCH_SW[4:0]]};

  // steer reads beyond the header into the string and patch outputs
  wire        in_hdr   = addr_ff < 16'h0020;
  wire        in_str   = addr_ff >= 16'(urcl_pkg::OFS_STR_MAKER) && addr_ff < 16'(urcl_pkg::OFS_PATCH);
  wire        in_patch = addr_ff >= 16'(urcl_pkg::OFS_PATCH);
  wire [15:0] str_off  = addr_ff - 16'(urcl_pkg::OFS_STR_MAKER);
  wire        last_b   = (addr_ff == 16'(IMG_BYTES - 1));
  wire        rd_take  = (st_ff == S_READ) && tw_done;

  //////////////////////////////////////////////////////////////////////////////
  // sequencer: random read from offset 0, then one sequential burst
  always_ff @(posedge i_mclk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      st_ff    <= S_STRAP;
      go_ff    <= 1'b0;
      op_ff    <= urcl_pkg::URCL_OP_STOP;
      wd_ff    <= 8'h00;
      last_ff  <= 1'b0;
      large_ff <= 1'b0;
      addr_ff  <= 16'h0000;
      sum_ff   <= 16'h0000;
    end
    else
    begin
      go_ff <= 1'b0;
      unique case (st_ff)
        S_STRAP:
        begin
          large_ff <= !i_scl;
          st_ff    <= S_START;
          op_ff    <= urcl_pkg::URCL_OP_START;
          go_ff    <= 1'b1;
        end
        S_START:
          if (tw_done)
          begin
            st_ff <= S_DEVW;
            op_ff <= urcl_pkg::URCL_OP_WRITE;
            wd_ff <= {urcl_pkg::DEV_ADDR, 1'b0};
            go_ff <= 1'b1;
          end
        S_DEVW:
          if (tw_done)
          begin
            // large roms take a two-byte address
            st_ff <= large_ff ? S_AH : S_AL;
            wd_ff <= 8'h00;
            go_ff <= 1'b1;
          end
        S_AH:
          if (tw_done)
          begin
            st_ff <= S_AL;
            go_ff <= 1'b1;
          end
        S_AL:
          if (tw_done)
          begin
            st_ff <= S_RSTART;
            op_ff <= urcl_pkg::URCL_OP_START;
            go_ff <= 1'b1;
          end
        S_RSTART:
          if (tw_done)
          begin
            st_ff <= S_DEVR;
            op_ff <= urcl_pkg::URCL_OP_WRITE;
            wd_ff <= {urcl_pkg::DEV_ADDR, 1'b1};
            go_ff <= 1'b1;
          end
        S_DEVR:
          if (tw_done)
          begin
            // an absent rom leaves the defaults in place
            st_ff   <= tw_nack ? S_STOP : S_READ;
            op_ff   <= tw_nack ? urcl_pkg::URCL_OP_STOP : urcl_pkg::URCL_OP_READ;
            last_ff <= 1'b0;
            go_ff   <= 1'b1;
          end
        S_READ:
          if (tw_done)
          begin
            sum_ff  <= sum_ff + 16'(tw_rdata);
            addr_ff <= addr_ff + 16'h0001;
            last_ff <= (addr_ff == 16'(IMG_BYTES - 2));
            op_ff   <= last_b ? urcl_pkg::URCL_OP_STOP : urcl_pkg::URCL_OP_READ;
            st_ff   <= last_b ? S_STOP : S_READ;
            go_ff   <= 1'b1;
          end
        S_STOP:
          if (tw_done)
            st_ff <= S_DONE;
        S_DONE:
          st_ff <= S_DONE;
        default: st_ff <= S_DONE;
      endcase
    end

  //////////////////////////////////////////////////////////////////////////////
  // header storage
  always_ff @(posedge i_mclk or negedge i_reset_n)
    if (!i_reset_n)
      for (int i = 0; i < 32; i++)
        hdr_ff[i] <= 8'h00;
    else if (rd_take && in_hdr)
      hdr_ff[addr_ff[4:0]] <= tw_rdata;

  //////////////////////////////////////////////////////////////////////////////
  // string and patch byte streams
  always_ff @(posedge i_mclk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      o_str_wr     <= 1'b0;
      o_str_sel    <= 2'h0;
      o_str_idx    <= 5'h00;
      o_str_data   <= 8'h00;
      o_patch_wr   <= 1'b0;
      o_patch_addr <= 16'h0000;
      o_patch_data <= 8'h00;
    end
    else
    begin
      o_str_wr   <= rd_take && in_str && {1'b0, str_off[4:0]} < 6'(STR_AREA_BYTES);
      o_str_sel  <= str_off[6:5];
      o_str_idx  <= str_off[4:0];
      o_str_data <= tw_rdata;
      // sum still open while patches stream, so gate on the mark and the patch switch word, not the sum
      o_patch_wr   <= rd_take && in_patch && mark_ok && w_patch != 16'h0000;
      o_patch_addr <= addr_ff - 16'(urcl_pkg::OFS_PATCH);
      o_patch_data <= tw_rdata;
    end

  //////////////////////////////////////////////////////////////////////////////
  // configuration outputs, registered from the decode
  wire done = (st_ff == S_DONE);

  always_ff @(posedge i_mclk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      o_load_done             <= 1'b0;
      o_image_valid           <= 1'b0;
      o_desc_flags            <= 16'h0000;
      o_id_vendor             <= 16'h0000;
      o_id_product            <= 16'h0000;
      o_bcd_device            <= 16'h0000;
      o_max_power             <= 8'h00;
      o_if_class              <= 8'h00;
      o_if_subclass           <= 8'h00;
      o_if_protocol           <= 8'h00;
      o_patch_enable          <= 1'b0;
      o_power_source_sel      <= 1'b0;
      o_clock_speed_sel       <= 1'b0;
      o_clk_is_7m5            <= 1'b0;
      o_device_type           <= urcl_pkg::DEV_AUTO;
      o_combo_mode            <= 1'b0;
      o_dma_capability_enable <= 1'b0;
      o_target_power_ctrl     <= 1'b0;
      o_tx_types              <= 16'h0001;
      o_udma_enable           <= 1'b0;
      o_mdma_enable           <= 1'b0;
      o_pio_enable            <= 1'b1;
      o_large_rom             <= 1'b0;
      o_arb_request_out       <= 1'b0;
    end
    else
    begin
      o_large_rom       <= large_ff;
      o_arb_request_out <= done && i_bus_request && !i_arb_peer_in;
      if (done && !o_load_done)
      begin
        o_load_done             <= 1'b1;
        o_image_valid           <= valid;
        o_desc_flags            <= valid ? {hdr_ff[5], hdr_ff[4]} : 16'h0000;
        o_id_vendor             <= valid ? {hdr_ff[9], hdr_ff[8]} : 16'h0000;
        o_id_product            <= valid ? {hdr_ff[11], hdr_ff[10]} : 16'h0000;
        o_bcd_device            <= valid ? {hdr_ff[13], hdr_ff[12]} : 16'h0000;
        o_max_power             <= !valid ? 8'h00 :
                                   power_source_sel ? hdr_ff[urcl_pkg::OFS_PWR_BUS[4:0]] :
                                         hdr_ff[urcl_pkg::OFS_PWR_SELF[4:0]];
        o_if_class              <= valid ? hdr_ff[urcl_pkg::OFS_IF_CLASS[4:0]] : 8'h00;
        o_if_subclass           <= valid ? hdr_ff[urcl_pkg::OFS_IF_SUB[4:0]] : 8'h00;
        o_if_protocol           <= valid ? hdr_ff[urcl_pkg::OFS_IF_PROTO[4:0]] : 8'h00;
        o_patch_enable          <= valid && w_patch != 16'h0000;
        o_power_source_sel      <= power_source_sel;
        o_clock_speed_sel       <= clock_speed_sel;
        o_clk_is_7m5            <= slow;
        o_device_type           <= dev;
        o_combo_mode            <= !power_source_sel && clock_speed_sel;
        o_dma_capability_enable <= dcc;
        o_target_power_ctrl     <= mode[urcl_pkg::MB_DPC];
        o_tx_types              <= tx_types;
        o_udma_enable           <= udma_ok;
        o_mdma_enable           <= mdma_ok;
      end
    end

endmodule // urcl_loader
`default_nettype wire

// >>> logic/urcl_twowire.sv
// two-wire serial rom byte engine
`timescale 1ns/100ps
`default_nettype none
module urcl_twowire #(
  parameter int HALF_CYC = urcl_pkg::SCL_HALF_CYC
) (
  input  wire logic               i_mclk,
  input  wire logic               i_reset_n,
  input  wire logic               i_go,
  input  wire urcl_pkg::urcl_op_e i_op,
  input  wire logic [7:0]         i_wdata,
  input  wire logic               i_last,
  input  wire logic               i_sda,
  output logic                    o_done,
  output logic [7:0]              o_rdata,
  output logic                    o_nack,
  output logic                    o_scl_oe,
  output logic                    o_sda_oe
);

  typedef enum logic [1:0] {IDLE, RUN} urcl_tw_e;
  urcl_tw_e           st_ff;
  urcl_pkg::urcl_op_e op_ff;
  logic [15:0]        div_ff;
  logic [1:0]         ph_ff;
  logic [3:0]         bit_ff;
  logic [8:0]         sh_ff;
  logic               scl_ff;
  logic               sda_ff;
  logic               last_ff;

  wire tick = (div_ff == 16'(HALF_CYC - 1));
  wire ph_end = tick && ph_ff == 2'h3;
  wire is_rd = (op_ff == urcl_pkg::URCL_OP_READ);
  wire is_byte = is_rd || op_ff == urcl_pkg::URCL_OP_WRITE;
  wire op_end = ph_end && (!is_byte || bit_ff == 4'h8);

  // open drain: enable pulls low
  assign o_scl_oe = !scl_ff;
  assign o_sda_oe = !sda_ff;

  //////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_mclk or negedge i_reset_n)
    if (!i_reset_n)
    begin
      st_ff   <= IDLE;
      op_ff   <= urcl_pkg::URCL_OP_STOP;
      div_ff  <= 16'h0000;
      ph_ff   <= 2'h0;
      bit_ff  <= 4'h0;
      sh_ff   <= 9'h1ff;
      scl_ff  <= 1'b1;
      sda_ff  <= 1'b1;
      last_ff <= 1'b0;
      o_done  <= 1'b0;
      o_rdata <= 8'h00;
      o_nack  <= 1'b0;
    end
    else
    begin
      o_done <= 1'b0;
      unique case (st_ff)
        IDLE:
          if (i_go)
          begin
            st_ff   <= RUN;
            op_ff   <= i_op;
            div_ff  <= 16'h0000;
            ph_ff   <= 2'h0;
            bit_ff  <= 4'h0;
            last_ff <= i_last;
            sh_ff   <= (i_op == urcl_pkg::URCL_OP_READ) ? {8'hff, i_last} : {i_wdata, 1'b1};
          end
        RUN:
        begin
          div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
          if (tick)
          begin
            ph_ff <= ph_ff + 2'h1;
            unique case (op_ff)
              urcl_pkg::URCL_OP_START:
                unique case (ph_ff)
                  2'h0: sda_ff <= 1'b1;
                  2'h1: scl_ff <= 1'b1;
                  2'h2: sda_ff <= 1'b0;
                  2'h3: scl_ff <= 1'b0;
                endcase
              urcl_pkg::URCL_OP_STOP:
                unique case (ph_ff)
                  2'h0: sda_ff <= 1'b0;
                  2'h1: scl_ff <= 1'b1;
                  2'h2: sda_ff <= 1'b1;
                  2'h3: sda_ff <= 1'b1;
                endcase
              default:
                unique case (ph_ff)
                  2'h0: sda_ff <= sh_ff[8];
                  2'h1: scl_ff <= 1'b1;
                  2'h2: sh_ff  <= {sh_ff[7:0], i_sda};
                  2'h3: scl_ff <= 1'b0;
                endcase
            endcase
          end
          if (ph_end && is_byte)
            bit_ff <= bit_ff + 4'h1;
          if (op_end)
          begin
            st_ff  <= IDLE;
            o_done <= 1'b1;
            o_rdata <= sh_ff[8:1];
            o_nack <= is_rd ? 1'b0 : sh_ff[0];
          end
        end
        default: st_ff <= IDLE;
      endcase
    end

endmodule // urcl_twowire
`default_nettype wire
